// File: vsm_defines.vh
// Register indices, field positions, reset values and sizes for vsync measurement
`ifndef VSM_DEFINES_VH
`define VSM_DEFINES_VH

// Register indices; the byte address on APB is four times the index
`define VSM_IDX_VS_POLARITY     10'h005
`define VSM_IDX_F0_ACTIVE_HI    10'h009
`define VSM_IDX_F0_ACTIVE_LO    10'h00A
`define VSM_IDX_F1_ACTIVE_HI    10'h00B
`define VSM_IDX_F1_ACTIVE_LO    10'h00C
`define VSM_IDX_F0_TOTAL_HI     10'h026
`define VSM_IDX_F0_TOTAL_LO     10'h027
`define VSM_IDX_F1_TOTAL_HI     10'h028
`define VSM_IDX_F1_TOTAL_LO     10'h029
`define VSM_IDX_F0_FRONT_HI     10'h02A
`define VSM_IDX_F1_FRONT_HI     10'h02C
`define VSM_IDX_F0_WIDTH_HI     10'h02E
`define VSM_IDX_F1_WIDTH_HI     10'h030
`define VSM_IDX_F0_BACK_HI      10'h032
`define VSM_IDX_F1_BACK_HI      10'h034
`define VSM_IDX_F1_BACK_LO      10'h035
`define VSM_IDX_LOCK_RAW        10'h06A

// Field positions
`define VSM_BIT_VS_POLARITY     4
`define VSM_BIT_INTERLACED      5
`define VSM_BIT_LOCK_RAW        1

// Measurement widths and number of result slots
`define VSM_HALF_W              14
`define VSM_ACTIVE_W            13
`define VSM_PAIRS               10

// Pair slots: first field at even slot, second field at odd slot
`define VSM_SLOT_TOTAL          4'h0
`define VSM_SLOT_FRONT          4'h2
`define VSM_SLOT_WIDTH          4'h4
`define VSM_SLOT_BACK           4'h6
`define VSM_SLOT_ACTIVE         4'h8

// Reset values
`define VSM_RST_MEAS            14'h0000
`define VSM_RST_POLARITY        1'b0
`define VSM_RST_LOCK            1'b0
`define VSM_RST_INTERLACED      1'b0

`endif

// File: vsm_field_meas.v
// One-field vertical timing counter working in half-line units
module vsm_field_meas (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        half_tick,
	input  wire        vs_lead,
	input  wire        vs_trail,
	input  wire        de_rise,
	input  wire        de_fall,
	output reg  [13:0] total,
	output reg  [12:0] active,
	output reg  [13:0] front,
	output reg  [13:0] width,
	output reg  [13:0] back,
	output reg         done
);

	reg        started;
	reg        got_de;
	reg [13:0] hl;
	reg [13:0] width_hl;
	reg [13:0] back_hl;
	reg [13:0] de_end_hl;
	reg [12:0] act_cnt;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			total     <= 14'h0000;
			active    <= 13'h0000;
			front     <= 14'h0000;
			width     <= 14'h0000;
			back      <= 14'h0000;
			done      <= 1'b0;
			started   <= 1'b0;
			got_de    <= 1'b0;
			hl        <= 14'h0000;
			width_hl  <= 14'h0000;
			back_hl   <= 14'h0000;
			de_end_hl <= 14'h0000;
			act_cnt   <= 13'h0000;
		end else begin
			done <= 1'b0;
			// Saturate so a lost vsync cannot wrap into a plausible count
			if (half_tick && hl != 14'h3FFF) begin
				hl <= hl + 14'h0001;
			end
			if (vs_trail) begin
				width_hl <= hl;
			end
			if (de_rise) begin
				if (act_cnt != 13'h1FFF) begin
					act_cnt <= act_cnt + 13'h0001;
				end
				if (!got_de) begin
					got_de  <= 1'b1;
					back_hl <= hl - width_hl;
				end
			end
			if (de_fall) begin
				de_end_hl <= hl;
			end
			if (vs_lead) begin
				// The first edge only opens a field; nothing to report yet
				if (started) begin
					total  <= hl;
					front  <= hl - de_end_hl;
					width  <= width_hl;
					back   <= back_hl;
					active <= act_cnt;
					done   <= 1'b1;
				end
				started   <= 1'b1;
				got_de    <= 1'b0;
				hl        <= 14'h0000;
				width_hl  <= 14'h0000;
				back_hl   <= 14'h0000;
				de_end_hl <= 14'h0000;
				act_cnt   <= 13'h0000;
			end
		end
	end

endmodule // vsm_field_meas

// File: vsm_sva.sv
// Assertions on the register side of the vsync measurement block
module vsm_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        vid_vsync,
	input wire logic        vid_hsync,
	input wire logic        vid_de
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire       acc = psel && penable && !pready;
	wire       ok  = pready && !pslverr;
	wire [9:0] idx = paddr[11:2];
	wire       hi  = idx > 10'h025 && idx < 10'h035 && !idx[0];
	wire       lo  = idx == 10'h00A || idx == 10'h00C ||
		(idx > 10'h026 && idx < 10'h036 && idx[0]);
	AST_ANSWER: assert property (acc |=> pready)
		else $error("access not answered");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_NOREQ: assert property (!acc |=> !pready)
		else $error("ready without access");
	AST_SILENT: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	AST_RO: assert property (acc && pwrite |=> pslverr && !prdata)
		else $error("write not refused");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_LOCK: assert property (ok && idx == 10'h06A |->
		prdata[31:2] == 30'h0 && !prdata[0]) else $error("lock bits");
	AST_POL: assert property (ok && idx == 10'h005 |->
		(prdata & 32'hFFFFFFEF) == 32'h0) else $error("polarity bits");
	AST_HI14: assert property (ok && hi |->
		prdata[31:6] == 26'h0) else $error("wide upper byte");
	AST_HI13: assert property (ok && idx == 10'h009 |->
		prdata[31:5] == 27'h0) else $error("active upper byte");
	AST_ILACE: assert property (ok && idx == 10'h00B |->
		prdata[31:6] == 26'h0) else $error("second upper byte");
	AST_LO: assert property (ok && lo |->
		prdata[31:8] == 24'h0) else $error("lower byte");
endmodule // vsm_sva

bind vsm_vsync_meas vsm_sva u_vsm_sva (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .vid_vsync(vid_vsync), .vid_hsync(vid_hsync),
	.vid_de(vid_de));

// File: vsm_video_src.sv
// Upstream video source with progressive and interlaced timing
module vsm_video_src #(
	parameter H = 40
) (
	input  wire logic pclk,
	input  wire logic pol,
	input  wire logic ilace,
	input  wire logic jit,
	output logic      vsync,
	output logic      hsync,
	output logic      de,
	output int        fields
);
	timeunit 1ns;
	timeprecision 1ps;
	int   x = 0;
	int   y = 0;
	int   p;
	int   wrap;
	logic tg = 0;
	logic vs;
	assign p = y * H + x;
	// Jitter lengthens every other progressive field so that no two consecutive totals match
	assign wrap = ilace ? 41 : 20 + (jit & tg);
	// Sync edges sit off the half-line ticks so counts are unambiguous
	assign vs = (p >= 2 && p < 3 * H + 2) ||
		(ilace && p >= 20 * H + 22 && p < 23 * H + 22);
	assign vsync = pol ? vs : !vs;
	assign hsync = pol ? x < 4 : x >= 4;
	assign de = x >= 10 && x < 34 &&
		((y >= 7 && y < 17) || (ilace && y >= 27 && y < 37));
	initial fields = 0;
	always @(posedge pclk) begin
		if (p == 2 || (ilace && p == 20 * H + 22))
			fields <= fields + 1;
		x <= (x == H - 1) ? 0 : x + 1;
		if (x == H - 1) begin
			y <= (y >= wrap - 1) ? 0 : y + 1;
			if (y >= wrap - 1)
				tg <= !tg;
		end
	end
endmodule // vsm_video_src

// File: vsm_vsync_meas.v
// Vertical sync measurement of the incoming video stream with APB readback
`include "vsm_defines.vh"

module vsm_vsync_meas #(
	parameter LINE_W = 16
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        vid_vsync,
	input  wire        vid_hsync,
	input  wire        vid_de
);

	// Pin synchronisers; stage 0 feeds stage 1 only
	reg [2:0] vs_sr;
	reg [2:0] hs_sr;
	reg [2:0] de_sr;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_sr <= 3'h0;
			hs_sr <= 3'h0;
			de_sr <= 3'h0;
		end else begin
			vs_sr <= {vs_sr[1:0], vid_vsync};
			hs_sr <= {hs_sr[1:0], vid_hsync};
			de_sr <= {de_sr[1:0], vid_de};
		end
	end

	// Sync levels seen during active video are the idle levels
	reg vs_pol;
	reg hs_pol;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vs_pol <= `VSM_RST_POLARITY;
			hs_pol <= `VSM_RST_POLARITY;
		end else if (de_sr[1]) begin
			vs_pol <= ~vs_sr[1];
			hs_pol <= ~hs_sr[1];
		end
	end

	wire vs_lead  = (vs_sr[1] == vs_pol) && (vs_sr[2] != vs_pol);
	wire vs_trail = (vs_sr[1] != vs_pol) && (vs_sr[2] == vs_pol);
	wire hs_lead  = (hs_sr[1] == hs_pol) && (hs_sr[2] != hs_pol);
	wire de_rise  = de_sr[1] && !de_sr[2];
	wire de_fall  = !de_sr[1] && de_sr[2];

	// Line length in clocks; the mid-line point gives the half-line tick
	reg  [LINE_W-1:0] line_cnt;
	reg  [LINE_W-1:0] line_len;
	reg               half_phase;
	wire              mid_tick;
	wire              half_tick;

	assign mid_tick  = !hs_lead && (line_len != {LINE_W{1'b0}}) &&
		(line_cnt == {1'b0, line_len[LINE_W-1:1]});
	assign half_tick = hs_lead | mid_tick;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_cnt   <= {LINE_W{1'b0}};
			line_len   <= {LINE_W{1'b0}};
			half_phase <= 1'b0;
		end else begin
			if (hs_lead) begin
				line_len   <= line_cnt;
				line_cnt   <= {{(LINE_W-1){1'b0}}, 1'b1};
				half_phase <= 1'b0;
			end else begin
				if (line_cnt != {LINE_W{1'b1}}) begin
					line_cnt <= line_cnt + {{(LINE_W-1){1'b0}}, 1'b1};
				end
				if (mid_tick) begin
					half_phase <= 1'b1;
				end
			end
		end
	end

	// A vsync at mid-line marks the second field of an interlaced frame
	wire next_phase = hs_lead ? 1'b0 : (mid_tick ? 1'b1 : half_phase);
	reg  cur_fid;
	reg  done_fid;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_fid  <= 1'b0;
			done_fid <= 1'b0;
		end else if (vs_lead) begin
			done_fid <= cur_fid;
			cur_fid  <= next_phase;
		end
	end

	wire [13:0] m_total;
	wire [12:0] m_active;
	wire [13:0] m_front;
	wire [13:0] m_width;
	wire [13:0] m_back;
	wire        m_done;

	vsm_field_meas u_field (
		.pclk      (pclk),
		.presetn   (presetn),
		.half_tick (half_tick),
		.vs_lead   (vs_lead),
		.vs_trail  (vs_trail),
		.de_rise   (de_rise),
		.de_fall   (de_fall),
		.total     (m_total),
		.active    (m_active),
		.front     (m_front),
		.width     (m_width),
		.back      (m_back),
		.done      (m_done)
	);

	// Lock filter and interlace detection, evaluated once per field
	reg        locked;
	reg        miss_once;
	reg        interlaced;
	reg        last_fid;
	reg        last_ok;
	reg [13:0] prev_total [0:1];
	reg [1:0]  prev_ok;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked        <= `VSM_RST_LOCK;
			miss_once     <= 1'b0;
			interlaced    <= `VSM_RST_INTERLACED;
			last_fid      <= 1'b0;
			last_ok       <= 1'b0;
			prev_total[0] <= `VSM_RST_MEAS;
			prev_total[1] <= `VSM_RST_MEAS;
			prev_ok       <= 2'b00;
		end else if (m_done) begin
			prev_total[done_fid] <= m_total;
			prev_ok[done_fid]    <= 1'b1;
			last_fid             <= done_fid;
			last_ok              <= 1'b1;
			interlaced <= last_ok && (done_fid != last_fid);
			if (prev_ok[done_fid] && prev_total[done_fid] == m_total) begin
				locked    <= 1'b1;
				miss_once <= 1'b0;
			end else if (miss_once) begin
				locked    <= 1'b0;
				miss_once <= 1'b0;
			end else begin
				miss_once <= 1'b1;
			end
		end
	end

	// Result words; a whole field set lands in one edge
	reg  [13:0] meas [0:`VSM_PAIRS-1];
	wire [3:0]  slot_f = {3'b000, done_fid};
	integer     j;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < `VSM_PAIRS; j = j + 1) begin
				meas[j] <= `VSM_RST_MEAS;
			end
		end else if (m_done) begin
			meas[`VSM_SLOT_TOTAL + slot_f]  <= m_total;
			meas[`VSM_SLOT_FRONT + slot_f]  <= m_front;
			meas[`VSM_SLOT_WIDTH + slot_f]  <= m_width;
			meas[`VSM_SLOT_BACK + slot_f]   <= m_back;
			meas[`VSM_SLOT_ACTIVE + slot_f] <= {1'b0, m_active};
		end
	end

	// Address decode for the read path
	wire [9:0] idx = paddr[11:2];
	wire [9:0] rel = idx - `VSM_IDX_F0_TOTAL_HI;
	reg        rd_hit;
	reg        rd_pair;
	reg        rd_hi;
	reg  [3:0] rd_k;
	reg [31:0] rd_data;
	reg  [7:0] hold_q [0:`VSM_PAIRS-1];

	always @* begin
		rd_hit  = 1'b0;
		rd_pair = 1'b0;
		rd_hi   = 1'b0;
		rd_k    = 4'h0;
		rd_data = 32'h00000000;
		if (idx >= `VSM_IDX_F0_TOTAL_HI && idx <= `VSM_IDX_F1_BACK_LO) begin
			rd_pair = 1'b1;
			rd_k    = rel[4:1];
			rd_hi   = ~idx[0];
		end else if (idx == `VSM_IDX_F0_ACTIVE_HI ||
			idx == `VSM_IDX_F0_ACTIVE_LO) begin
			rd_pair = 1'b1;
			rd_k    = `VSM_SLOT_ACTIVE;
			rd_hi   = (idx == `VSM_IDX_F0_ACTIVE_HI);
		end else if (idx == `VSM_IDX_F1_ACTIVE_HI ||
			idx == `VSM_IDX_F1_ACTIVE_LO) begin
			rd_pair = 1'b1;
			rd_k    = `VSM_SLOT_ACTIVE + 4'h1;
			rd_hi   = (idx == `VSM_IDX_F1_ACTIVE_HI);
		end
		if (rd_pair) begin
			rd_hit = 1'b1;
			if (rd_hi) begin
				rd_data[5:0] = meas[rd_k][13:8];
			end else begin
				rd_data[7:0] = hold_q[rd_k];
			end
			if (idx == `VSM_IDX_F1_ACTIVE_HI) begin
				// Unlocked filter cannot vouch for the field sequence
				rd_data[`VSM_BIT_INTERLACED] = interlaced & locked;
			end
		end else if (idx == `VSM_IDX_VS_POLARITY) begin
			rd_hit = 1'b1;
			rd_data[`VSM_BIT_VS_POLARITY] = vs_pol;
		end else if (idx == `VSM_IDX_LOCK_RAW) begin
			rd_hit = 1'b1;
			rd_data[`VSM_BIT_LOCK_RAW] = locked;
		end
	end

	// Reading the upper byte freezes its lower byte for the next read
	wire       apb_access = psel && penable && !pready;
	wire       hi_read    = apb_access && !pwrite && rd_pair && rd_hi;

	genvar g;
	generate
		for (g = 0; g < `VSM_PAIRS; g = g + 1) begin : g_hold
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					hold_q[g] <= 8'h00;
				end else if (hi_read && rd_k == g) begin
					hold_q[g] <= meas[g][7:0];
				end
			end
		end
	endgenerate

	// APB slave: one wait state, every register read-only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (apb_access) begin
			pready  <= 1'b1;
			pslverr <= pwrite || !rd_hit;
			prdata  <= (pwrite || !rd_hit) ? 32'h00000000 : rd_data;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
	end

	// Write data is ignored: the map holds no writable bit
	wire unused_wdata = ^pwdata;

endmodule // vsm_vsync_meas

// File: vsm_vsync_meas_tb.sv
// Self-checking bench for vsync measurement with register reads
`include "vsm_defines.vh"
module vsm_vsync_meas_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready, pslverr, vs, hs, de;
	logic        pol = 1;
	logic        il = 0;
	logic        jit = 0;
	logic [64:0] q[$];
	logic [64:0] n;
	int          fields, k;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	always #2 pclk = ~pclk;
	vsm_vsync_meas u_vsm_vsync_meas (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .vid_vsync(vs), .vid_hsync(hs), .vid_de(de));
	vsm_video_src u_vsm_video_src (.pclk(pclk), .pol(pol), .ilace(il),
		.jit(jit), .vsync(vs), .hsync(hs), .de(de), .fields(fields));
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	always @(posedge pclk) if (pready === 1'b1) begin
		n = q.pop_front();
		chk(prdata & n[63:32], n[31:0]);
		chk({31'h0, pslverr}, {31'h0, n[64]});
	end
	task acc(input logic [9:0] i, input logic w, input logic er,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge pclk);
		q.push_back({er, m, e});
		psel <= 1;
		paddr <= {i, 2'b00};
		pwrite <= w;
		pwdata <= $urandom;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	// Upper byte first: it freezes the lower byte against tearing
	task rd16(input logic [9:0] i, input logic [15:0] v);
		acc(i, 0, 0, {24'h0, v[15:8]}, '1);
		acc(i + 10'h1, 0, 0, {24'h0, v[7:0]}, '1);
	endtask
	task field(input logic s, input logic [15:0] t, input logic [15:0] f,
		input logic [15:0] b, input logic [15:0] a);
		logic [9:0] o;
		o = s ? 10'h2 : 10'h0;
		rd16(`VSM_IDX_F0_TOTAL_HI + o, t);
		rd16(`VSM_IDX_F0_ACTIVE_HI + o, a);
		rd16(`VSM_IDX_F0_FRONT_HI + o, f);
		rd16(`VSM_IDX_F0_WIDTH_HI + o, 16'd6);
		rd16(`VSM_IDX_F0_BACK_HI + o, b);
	endtask
	task settle(input int c);
		int f0;
		f0 = fields;
		wait (fields >= f0 + c);
		repeat (8) @(posedge pclk);
	endtask
	task tally_and_finish;
		$display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial begin
		void'($urandom(11446));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		acc(`VSM_IDX_LOCK_RAW, 0, 0, 0, '1);
		acc(`VSM_IDX_VS_POLARITY, 0, 0, 0, '1);
		rd16(`VSM_IDX_F0_TOTAL_HI, 16'd0);
		$display("test reset done");
		settle(4);
		acc(`VSM_IDX_LOCK_RAW, 0, 0, 32'h2, 32'h2);
		acc(`VSM_IDX_VS_POLARITY, 0, 0, 32'h10, 32'h10);
		acc(`VSM_IDX_F1_ACTIVE_HI, 0, 0, 0, 32'h20);
		// Progressive modes judged from the first field alone
		field(0, 16'd40, 16'd7, 16'd8, 16'd10);
		$display("test progressive done");
		for (k = 0; k < 4; k++) begin
			acc(`VSM_IDX_F0_TOTAL_HI, 1, 1, 0, '1);
			acc(10'h040 + 10'($urandom % 16), 0, 1, 0, '1);
		end
		rd16(`VSM_IDX_F0_TOTAL_HI, 16'd40);
		$display("test refusals done");
		pol <= 0;
		settle(3);
		acc(`VSM_IDX_VS_POLARITY, 0, 0, 0, 32'h10);
		$display("test polarity done");
		pol <= 1;
		il <= 1;
		settle(6);
		acc(`VSM_IDX_LOCK_RAW, 0, 0, 32'h2, 32'h2);
		field(0, 16'd41, 16'd8, 16'd8, 16'd10);
		field(1, 16'd41, 16'd9, 16'd7, 16'h200A);
		$display("test interlaced done");
		il <= 0;
		jit <= 1;
		settle(6);
		acc(`VSM_IDX_LOCK_RAW, 0, 0, 0, 32'h2);
		acc(`VSM_IDX_F1_ACTIVE_HI, 0, 0, 0, 32'h20);
		$display("test unlock done");
		@(posedge pclk);
		tally_and_finish;
	end
endmodule // vsm_vsync_meas_tb
